// *** logic/host_irq_mask_gate.sv ***
`timescale 1ns/1ps
`include "host_irq_mask_gate_map.svh"

module host_irq_mask_gate (
    input  wire logic        i_core_clk,          // 40 MHz core clock
    input  wire logic        i_rst_n,             // async reset, active low
    input  wire logic [7:0]  i_avs_address,       // byte address
    input  wire logic        i_avs_read,          // read request
    input  wire logic        i_avs_write,         // write request
    input  wire logic [31:0] i_avs_writedata,     // write data
    input  wire logic [3:0]  i_avs_byteenable,    // byte lanes
    input  wire logic [31:0] i_irq_event,         // event register contents
    output logic      [31:0] o_avs_readdata,      // read data, registered
    output logic             o_avs_waitrequest,   // stall, registered
    output logic             o_irq,               // external interrupt request
    output logic      [31:0] o_irq_mask           // current mask contents
);
    host_irq_mask_gate_pkg::bus_state_t bus_state_reg;   // slave phase
    host_irq_mask_gate_pkg::word_t      mask_reg;        // mask storage
    host_irq_mask_gate_pkg::word_t      mask_next;       // next mask
    host_irq_mask_gate_pkg::word_t      lane_mask;       // byte-enable expansion
    host_irq_mask_gate_pkg::word_t      read_value;      // decoded read word
    logic [31:0]                        pending;         // per-source masked events
    logic                               take;            // request accepted this edge
    logic                               hit_set;         // set alias addressed
    logic                               hit_clear;       // clear alias addressed

    // alias decode
    assign hit_set   = (i_avs_address == `IRQ_MASK_SET_OFS);
    assign hit_clear = (i_avs_address == `IRQ_MASK_CLEAR_OFS);
    // a request is taken in the idle phase
    assign take = (bus_state_reg == host_irq_mask_gate_pkg::BUS_IDLE)
                  & (i_avs_read | i_avs_write);

    // byte enables to a bit mask
    always_comb begin
        lane_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                     {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    end

    // set and clear alias write effects
    always_comb begin
        mask_next = mask_reg;
        if (take && i_avs_write) begin
            if (hit_set) begin
                // ones set, zeros leave the bit alone
                mask_next = mask_reg | (i_avs_writedata & lane_mask);
            end else if (hit_clear) begin
                // ones clear, zeros leave the bit alone
                mask_next = mask_reg & ~(i_avs_writedata & lane_mask);
            end
        end
        // reserved bits forced to zero
        mask_next = mask_next & `IRQ_MASK_WRITABLE;
    end

    // read decode: both aliases give the same word
    always_comb begin
        if (hit_set || hit_clear) begin
            read_value = mask_reg;
        end else begin
            read_value = `IRQ_UNMAPPED_READ; // unmapped reads zero
        end
    end

    // mask storage
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mask_reg <= `IRQ_MASK_RESET;
        end else begin
            mask_reg <= mask_next;
        end
    end

    // slave phase: one wait cycle, then answer
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_state_reg <= host_irq_mask_gate_pkg::BUS_IDLE;
        end else begin
            case (bus_state_reg)
                host_irq_mask_gate_pkg::BUS_IDLE: begin
                    if (take) begin
                        bus_state_reg <= host_irq_mask_gate_pkg::BUS_ANSWER;
                    end
                end
                host_irq_mask_gate_pkg::BUS_ANSWER: begin
                    bus_state_reg <= host_irq_mask_gate_pkg::BUS_IDLE;
                end
                default: begin
                    bus_state_reg <= host_irq_mask_gate_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // waitrequest: low only in the answer cycle
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= ~take;
        end
    end

    // read data captured at accept
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_readdata <= 32'h00000000;
        end else if (take && i_avs_read) begin
            o_avs_readdata <= read_value;
        end
    end

    // mask copy for observation
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_mask <= `IRQ_MASK_RESET;
        end else begin
            o_irq_mask <= mask_next;
        end
    end

    // per-source and of mask and event
    irq_source_gate u_gate (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_mask     (mask_reg),
        .i_event    (i_irq_event),
        .o_pending  (pending)
    );

    // external interrupt: global gate over any enabled source
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= mask_reg[`IRQ_GLOBAL_GATE_BIT]
                     & (|pending[`IRQ_GLOBAL_GATE_BIT-1:0]);
        end
    end
endmodule : host_irq_mask_gate

// *** logic/host_irq_mask_gate_map.svh ***
`ifndef HOST_IRQ_MASK_GATE_MAP_SVH
`define HOST_IRQ_MASK_GATE_MAP_SVH

// byte addresses of the two aliases
`define IRQ_MASK_SET_OFS       8'h88
`define IRQ_MASK_CLEAR_OFS     8'h8C
// field positions
`define IRQ_GLOBAL_GATE_BIT    31
`define IRQ_MAKER_BIT          30
`define IRQ_SOFT_BIT           29
`define IRQ_CENSUS_BIT         16
`define IRQ_CENSUS_STICKY_BIT  15
// bits that may hold a one (28 and 14..10 read zero)
`define IRQ_MASK_WRITABLE      32'hEFFF83FF
// reset value of the mask (unknown bits settle to zero)
`define IRQ_MASK_RESET         32'h00000000
// value answered to an unmapped read
`define IRQ_UNMAPPED_READ      32'h00000000
// number of event sources
`define IRQ_SOURCES            32

`endif

// *** logic/host_irq_mask_gate_pkg.sv ***
package host_irq_mask_gate_pkg;
    // bus slave phase
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_t;
    // register word
    typedef logic [31:0] word_t;
endpackage : host_irq_mask_gate_pkg

// *** logic/irq_source_gate.sv ***
`timescale 1ns/1ps
`include "host_irq_mask_gate_map.svh"

// per-source and gate: one registered pending bit per source
module irq_source_gate (
    input  wire logic                        i_core_clk,   // core clock
    input  wire logic                        i_rst_n,      // async reset, active low
    input  wire logic [`IRQ_SOURCES-1:0]     i_mask,       // mask contents
    input  wire logic [`IRQ_SOURCES-1:0]     i_event,      // event contents
    output logic      [`IRQ_SOURCES-1:0]     o_pending     // masked events, registered
);
    genvar g;
    // one flop per source, positions align between mask and event
    generate
        for (g = 0; g < `IRQ_SOURCES; g = g + 1) begin : g_src
            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_pending[g] <= 1'b0;
                end else begin
                    o_pending[g] <= i_mask[g] & i_event[g];
                end
            end
        end
    endgenerate
endmodule : irq_source_gate

// *** bench/host_irq_mask_gate_chk.sv ***
`timescale 1ns/1ps
`include "host_irq_mask_gate_map.svh"
// watches bus answers, alias updates and the gated request
module host_irq_mask_gate_chk (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    input  wire logic [31:0] i_irq_event,
    input  wire logic [31:0] o_avs_readdata,
    input  wire logic        o_avs_waitrequest,
    input  wire logic        o_irq,
    input  wire logic [31:0] o_irq_mask
);
    // write data limited to enabled lanes
    wire [31:0] bem = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                       {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    wire [31:0] wbits = i_avs_writedata & bem;
    // request the mask should produce
    wire        gated = o_irq_mask[31] & |(o_irq_mask[30:0] & i_irq_event[30:0]);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // request taken while slave idle
    sequence s_take;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    // write taken at a given alias
    sequence s_wr(a);
        s_take ##0 (i_avs_write && i_avs_address == a);
    endsequence
    AST_RSVD: assert property (o_irq_mask[28] == 1'h0 && o_irq_mask[14:10] == 5'h00)
        else $error("reserved mask bit holds one");
    AST_ANSWER: assert property (s_take |=> !o_avs_waitrequest)
        else $error("no answer one cycle after request");
    AST_ONE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("answer stood longer than one cycle");
    AST_CAUSE: assert property (!o_avs_waitrequest |-> $past(i_avs_read || i_avs_write))
        else $error("answer without request");
    AST_SET: assert property (s_wr(8'h88) |=>
        o_irq_mask == ($past(o_irq_mask) | ($past(wbits) & `IRQ_MASK_WRITABLE)))
        else $error("set alias did not set bits");
    AST_CLR: assert property (s_wr(8'h8C) |=> o_irq_mask == ($past(o_irq_mask) & ~$past(wbits)))
        else $error("clear alias did not clear bits");
    AST_READ: assert property (s_take ##0 (i_avs_read && (i_avs_address == 8'h88 ||
        i_avs_address == 8'h8C)) |=> o_avs_readdata == o_irq_mask)
        else $error("alias read differs from mask");
    AST_GATE: assert property ($past(o_irq_mask) == $past(o_irq_mask, 2) &&
        $past(i_irq_event) == $past(i_irq_event, 2) |-> o_irq == $past(gated, 2))
        else $error("interrupt request differs from mask and events");
endmodule : host_irq_mask_gate_chk

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`include "host_irq_mask_gate_map.svh"
module testbench;
    logic        clk = 1'h0;             // core clock
    logic        rst_n = 1'h0;           // reset, active low
    logic [7:0]  addr = 8'h00;           // bus address
    logic        rd = 1'h0, wr = 1'h0;   // bus direction
    logic [31:0] wd = 32'h0, ev = 32'h0; // write data, events
    logic [3:0]  ben = 4'hF;             // byte lanes
    logic [31:0] rdata, mask, q;         // design outputs, read result
    logic        wreq, irq;              // stall, interrupt
    int          failures = 0, n_tests = 0;
    host_irq_mask_gate u_host_irq_mask_gate (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(ben), .i_irq_event(ev), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .o_irq(irq), .o_irq_mask(mask));
    always #12.5 clk = ~clk;
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task test_done;
        $display("failures %0d tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // one access, held until the answer comes
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        @(posedge clk);
        {rd, wr, addr, wd, ben} <= {~w, w, a, d, b};
        n = 0;
        // sample waitrequest at each rising edge, bounded
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'h0 && n < 20);
        if (wreq !== 1'h0) begin
            failures++;
            test_done();
        end
        // read data stand at the edge that sees waitrequest low
        q = rdata;
        {rd, wr} <= 2'h0;
    endtask : bus
    // reset holds outputs at rest
    task t_reset;
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk("reset mask", mask, `IRQ_MASK_RESET);
        chk("reset flags", {30'h0, irq, wreq}, 32'h1);
        chk("reset rdata", rdata, 32'h0);
        @(posedge clk);
        rst_n <= 1'h1;
    endtask : t_reset
    // lanes, both aliases, reserved bits, unmapped place
    task t_alias;
        bus(1'h1, 8'h88, 32'hFFFFFFFF, 4'hF);
        bus(1'h0, 8'h8C, 32'h0, 4'hF);
        chk("clear alias read", q, `IRQ_MASK_WRITABLE);
        bus(1'h1, 8'h8C, 32'hFFFFFFFF, 4'hA);
        bus(1'h1, 8'h88, 32'h0, 4'hF);
        bus(1'h1, 8'h90, 32'hFFFFFFFF, 4'hF);
        bus(1'h0, 8'h88, 32'h0, 4'hF);
        chk("lane clear", q, 32'h00FF00FF);
        bus(1'h0, 8'h90, 32'h0, 4'hF);
        chk("unmapped read", q, 32'h0);
    endtask : t_alias
    // each source, then all other events, then the global gate
    task t_sources;
        for (int i = 0; i < 31; i++) begin
            if (i == 28 || (i >= 10 && i <= 14)) continue;
            bus(1'h1, 8'h8C, 32'hFFFFFFFF, 4'hF);
            bus(1'h1, 8'h88, 32'h80000000 | (32'h1 << i), 4'hF);
            ev <= 32'h1 << i;
            repeat (3) @(negedge clk);
            chk("source on", irq, 32'h1);
            @(negedge clk);
            chk("source held", irq, 32'h1);
            @(posedge clk);
            ev <= ~(32'h1 << i);
            repeat (3) @(negedge clk);
            chk("other events", irq, 32'h0);
            bus(1'h1, 8'h8C, 32'h80000000, 4'h8);
            ev <= 32'h1 << i;
            repeat (3) @(negedge clk);
            chk("global gate", irq, 32'h0);
        end
    endtask : t_sources
    initial begin
        t_reset();
        t_alias();
        t_reset();
        t_sources();
        test_done();
    end
endmodule : testbench
bind host_irq_mask_gate host_irq_mask_gate_chk u_host_irq_mask_gate_chk (.*);
